// file: rtl/aics_pkg.sv
package aics_pkg;

    // clock of the block
    localparam int unsigned CLK_NS          = 4;

    // power-on reset wait after the supply is good
    localparam int unsigned POR_TIME_NS     = 500000;
    localparam int unsigned POR_CYC         = POR_TIME_NS / CLK_NS;
    localparam int unsigned POR_CNT_W       = 17;

    // internal serial clock, half period
    localparam int unsigned SCK_HALF_NS     = 80;
    localparam int unsigned SCK_HALF_CYC_I  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  SCK_HALF_CYC    = SCK_HALF_CYC_I[7:0];
    localparam logic [7:0]  SCK_HALF_LAST   = SCK_HALF_CYC - 8'h01;

    // output frame
    localparam int unsigned FRAME_BITS      = 24;
    localparam logic [4:0]  FRAME_LAST      = 5'h18;
    localparam int unsigned RESULT_W        = FRAME_BITS - 1;
    localparam logic        EOC_BUSY        = 1'b1;
    localparam logic        EOC_READY       = 1'b0;

    // result buffer
    localparam int unsigned FIFO_DEPTH      = 8;

    // sleep length counter
    localparam int unsigned SLEEP_W         = 16;
    localparam logic [15:0] SLEEP_DEFAULT   = 16'h0100;

    // pin synchroniser lanes
    localparam int unsigned PIN_N           = 3;
    localparam int unsigned PIN_SUPPLY      = 0;
    localparam int unsigned PIN_CS          = 1;
    localparam int unsigned PIN_SCK         = 2;

    typedef enum logic [4:0] {
        ST_POR   = 5'b00001,
        ST_CONV  = 5'b00010,
        ST_SLEEP = 5'b00100,
        ST_FRAME = 5'b01000,
        ST_IDLE  = 5'b10000
    } aics_state_t;

endpackage

// file: rtl/aics_pin_sync.sv
`timescale 1ns/10ps
module aics_pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] lvl_o
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    ff1[g]   <= 1'b0;
                    ff2[g]   <= 1'b0;
                    ff3[g]   <= 1'b0;
                    lvl_o[g] <= 1'b0;
                end else begin
                    ff1[g] <= pin_i[g];
                    ff2[g] <= ff1[g];
                    ff3[g] <= ff2[g];
                    // a change counts once the last two agree
                    if (ff2[g] == ff3[g]) begin
                        lvl_o[g] <= ff3[g];
                    end
                end
            end
        end
    endgenerate

endmodule

// file: rtl/aics_fifo.sv
`timescale 1ns/10ps
module aics_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          fetch;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign push       = in_valid_i && in_ready_o;
    // output stage refills when empty or being drained
    assign fetch      = (count != '0) && (!out_valid_o || out_ready_i);

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (fetch) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !fetch) begin
                count <= count + 1'b1;
            end else if (!push && fetch) begin
                count <= count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (fetch) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rd_ptr];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

endmodule

// file: rtl/aics_serial_out.sv
// Notes on behaviour
// - clock mode decided when power-on wait ends
// - clock pin high selects internal, low external
// - converting: clock and data outputs held high
// - conversion done: clock, data low, sleep
// - sleep half period, then frame unprompted
// - frame spans 24 rising edges, data on falls
// - after 24th rise: data high, clock high
// - autostart: chip select pulled high converting
// - autostart sleep sinks current from chip select
// - autostart: chip select low starts frame
// - autostart: after frame, release select, reconvert
// - each select crossing in autostart sleep re-decides clock mode
// - finished result loads shift register at flag fall
`timescale 1ns/10ps
module aics_serial_out
    import aics_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    input  wire logic                supply_ok_i,
    input  wire logic                sck_i,
    output logic                     sck_o,
    output logic                     sck_oe_o,
    output logic                     sck_pullup_o,
    input  wire logic                cs_i,
    output logic                     cs_pullup_o,
    output logic                     cs_sink_o,
    output logic                     sdo_o,
    output logic                     sdo_oe_o,
    output logic                     conv_start_o,
    input  wire logic                res_valid_i,
    output logic                     res_ready_o,
    input  wire logic [RESULT_W-1:0] res_data_i,
    input  wire logic [SLEEP_W-1:0]  sleep_cycles_i,
    output logic                     ext_mode_o,
    output logic                     autostart_o,
    output logic                     converting_o
);

    aics_state_t           state;
    logic [PIN_N-1:0]      pin_raw;
    logic [PIN_N-1:0]      pin_lvl;
    logic [PIN_N-1:0]      pin_prev;
    logic                  supply_lvl;
    logic                  cs_lvl;
    logic                  sck_lvl;
    logic                  cs_fall;
    logic                  sck_rise;
    logic                  sck_fall;
    logic [POR_CNT_W-1:0]  por_cnt;
    logic                  por_done;
    logic                  buf_valid;
    logic                  buf_pop;
    logic [RESULT_W-1:0]   buf_data;
    logic [RESULT_W-1:0]   shreg;
    logic                  shift_en;
    logic [7:0]            hcnt;
    logic                  half_tick;
    logic [4:0]            ecnt;
    logic [SLEEP_W-1:0]    slp_cnt;
    logic                  slp_min_done;
    logic                  slp_cfg_done;
    logic                  int_start;
    logic                  auto_start;
    logic                  lead_in;
    logic                  auto_arm;

    assign pin_raw[PIN_SUPPLY] = supply_ok_i;
    assign pin_raw[PIN_CS]     = cs_i;
    assign pin_raw[PIN_SCK]    = sck_i;

    aics_pin_sync #(
        .W        (PIN_N)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (pin_raw),
        .lvl_o    (pin_lvl)
    );

    assign supply_lvl = pin_lvl[PIN_SUPPLY];
    assign cs_lvl     = pin_lvl[PIN_CS];
    assign sck_lvl    = pin_lvl[PIN_SCK];

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_lvl;
        end
    end

    assign cs_fall  = pin_prev[PIN_CS] && !cs_lvl;
    assign sck_rise = !pin_prev[PIN_SCK] && sck_lvl;
    assign sck_fall = pin_prev[PIN_SCK] && !sck_lvl;

    // power-on wait, restarted whenever the supply drops
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            por_cnt <= '0;
        end else if (!supply_lvl) begin
            por_cnt <= '0;
        end else if (!por_done) begin
            por_cnt <= por_cnt + 1'b1;
        end
    end

    assign por_done = (por_cnt == POR_CYCLES[POR_CNT_W-1:0]);

    aics_fifo #(
        .W           (RESULT_W),
        .DEPTH       (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (res_valid_i),
        .in_ready_o  (res_ready_o),
        .in_data_i   (res_data_i),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_data)
    );

    // a buffered result ends the running conversion
    assign buf_pop = (state == ST_CONV) && buf_valid;

    // half-period timer of the internal serial clock
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hcnt <= '0;
        end else if ((state != ST_FRAME && !lead_in) || half_tick) begin
            hcnt <= '0;
        end else begin
            hcnt <= hcnt + 8'h01;
        end
    end

    assign half_tick = (hcnt == SCK_HALF_LAST);

    // sleep timer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            slp_cnt <= '0;
        end else if (state != ST_SLEEP) begin
            slp_cnt <= '0;
        end else if (slp_cnt != '1) begin
            slp_cnt <= slp_cnt + 1'b1;
        end
    end

    assign slp_min_done = (slp_cnt >= {{(SLEEP_W-8){1'b0}}, SCK_HALF_LAST});
    assign slp_cfg_done = (slp_cnt >= sleep_cycles_i);
    assign int_start    = (state == ST_SLEEP) && !ext_mode_o && !autostart_o && slp_min_done;
    assign auto_start   = (state == ST_SLEEP) && !ext_mode_o && lead_in && half_tick
                          && slp_cfg_done && slp_min_done;

    // autostart lead-in: after the crossing the pin is driven low for a
    // half period, so the controller sees a true first rising edge
    assign lead_in      = (state == ST_SLEEP) && autostart_o && sck_oe_o;
    assign auto_arm     = (state == ST_SLEEP) && autostart_o && !ext_mode_o && !sck_oe_o
                          && cs_fall && sck_lvl;

    // a falling clock edge in the frame moves the next bit out
    always_comb begin
        shift_en = 1'b0;
        if (state == ST_FRAME && ecnt != FRAME_LAST) begin
            if (ext_mode_o) begin
                shift_en = sck_fall;
            end else begin
                shift_en = half_tick && sck_o;
            end
        end
    end

    // result shift register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            shreg <= '0;
        end else if (buf_pop) begin
            shreg <= buf_data;
        end else if (shift_en) begin
            shreg <= {shreg[RESULT_W-2:0], 1'b0};
        end
    end

    // clock mode: decided at power-on and at each select crossing in autostart sleep
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ext_mode_o <= 1'b0;
        end else if (state == ST_POR && por_done) begin
            ext_mode_o <= !sck_lvl;
        end else if (state == ST_SLEEP && autostart_o && cs_fall) begin
            ext_mode_o <= !sck_lvl;
        end
    end

    // autostart when the select pin is still high as the conversion ends, in internal clock mode only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            autostart_o <= 1'b0;
        end else if (buf_pop) begin
            autostart_o <= cs_lvl && !ext_mode_o;
        end
    end

    // sequencer: state, pins and edge count
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state        <= ST_POR;
            sck_o        <= 1'b1;
            sck_oe_o     <= 1'b0;
            sck_pullup_o <= 1'b1;
            sdo_o        <= EOC_BUSY;
            sdo_oe_o     <= 1'b0;
            cs_pullup_o  <= 1'b1;
            cs_sink_o    <= 1'b0;
            conv_start_o <= 1'b0;
            ecnt         <= '0;
        end else begin
            conv_start_o <= 1'b0;
            if (!supply_lvl) begin
                state        <= ST_POR;
                sck_o        <= 1'b1;
                sck_oe_o     <= 1'b0;
                sck_pullup_o <= 1'b1;
                sdo_o        <= EOC_BUSY;
                sdo_oe_o     <= 1'b0;
                cs_pullup_o  <= 1'b1;
                cs_sink_o    <= 1'b0;
                ecnt         <= '0;
            end else begin
                case (state)
                    ST_POR: begin
                        if (por_done) begin
                            state        <= ST_CONV;
                            conv_start_o <= 1'b1;
                            sck_o        <= 1'b1;
                            sck_oe_o     <= sck_lvl;
                            sck_pullup_o <= 1'b1;
                            sdo_o        <= EOC_BUSY;
                            sdo_oe_o     <= 1'b1;
                            cs_pullup_o  <= 1'b1;
                        end
                    end
                    ST_CONV: begin
                        sck_o       <= 1'b1;
                        sdo_o       <= EOC_BUSY;
                        cs_pullup_o <= 1'b1;
                        cs_sink_o   <= 1'b0;
                        if (buf_pop) begin
                            state     <= ST_SLEEP;
                            sdo_o     <= EOC_READY;
                            sck_o     <= 1'b0;
                            ecnt      <= '0;
                            if (!ext_mode_o && cs_lvl) begin
                                // pin released to the pull-up while the capacitor drains
                                sck_oe_o     <= 1'b0;
                                sck_pullup_o <= 1'b1;
                                cs_pullup_o  <= 1'b0;
                                cs_sink_o    <= 1'b1;
                            end else begin
                                sck_oe_o     <= !ext_mode_o;
                                sck_pullup_o <= ext_mode_o;
                            end
                        end
                    end
                    ST_SLEEP: begin
                        if (ext_mode_o) begin
                            sck_oe_o     <= 1'b0;
                            sck_pullup_o <= 1'b1;
                            if (sck_rise) begin
                                state <= ST_FRAME;
                                ecnt  <= 5'h01;
                            end
                        end else if (int_start || auto_start) begin
                            state        <= ST_FRAME;
                            sck_o        <= 1'b1;
                            sck_oe_o     <= 1'b1;
                            sck_pullup_o <= 1'b0;
                            cs_sink_o    <= 1'b0;
                            ecnt         <= 5'h01;
                        end else if (auto_arm) begin
                            // discharge over: clock pin driven low ahead of the frame
                            sck_oe_o     <= 1'b1;
                            sck_pullup_o <= 1'b0;
                            cs_sink_o    <= 1'b0;
                        end
                    end
                    ST_FRAME: begin
                        if (ext_mode_o) begin
                            if (sck_rise && ecnt != FRAME_LAST) begin
                                ecnt <= ecnt + 5'h01;
                            end
                            if (sck_fall) begin
                                if (ecnt == FRAME_LAST) begin
                                    state        <= ST_CONV;
                                    conv_start_o <= 1'b1;
                                    sdo_o        <= EOC_BUSY;
                                    cs_pullup_o  <= 1'b1;
                                end else begin
                                    sdo_o <= shreg[RESULT_W-1];
                                end
                            end
                        end else if (half_tick) begin
                            if (sck_o) begin
                                if (ecnt == FRAME_LAST) begin
                                    // last bit has been taken; clock stays high
                                    state        <= ST_CONV;
                                    conv_start_o <= 1'b1;
                                    sdo_o        <= EOC_BUSY;
                                    sck_o        <= 1'b1;
                                    sck_pullup_o <= 1'b1;
                                    cs_pullup_o  <= 1'b1;
                                end else begin
                                    sck_o <= 1'b0;
                                    sdo_o <= shreg[RESULT_W-1];
                                end
                            end else begin
                                sck_o <= 1'b1;
                                ecnt  <= ecnt + 5'h01;
                            end
                        end
                    end
                    default: begin
                        state <= ST_POR;
                    end
                endcase
            end
        end
    end

    assign converting_o = (state == ST_CONV);

endmodule

// file: verification/aics_serial_out_asserts.sv
`timescale 1ns/10ps
module aics_serial_out_asserts
    import aics_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CYC
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sck_o,
    input wire logic sck_oe_o,
    input wire logic sck_pullup_o,
    input wire logic cs_pullup_o,
    input wire logic cs_sink_o,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic conv_start_o,
    input wire logic ext_mode_o,
    input wire logic converting_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic [4:0] rises;

    // rising edges of the driven clock since the last conversion
    always_ff @(posedge clk_i) begin
        if (!resetn_i || converting_o) begin
            rises <= 5'h00;
        end else if ($rose(sck_o) && sck_oe_o) begin
            rises <= rises + 5'h01;
        end
    end

    sequence s_low_half;
        (!sck_o || !sck_oe_o) [*8] ##1 (!sck_o || !sck_oe_o) [*8] ##1 (!sck_o || !sck_oe_o) [*4];
    endsequence
    sequence s_high_half;
        sck_o [*8] ##1 sck_o [*8] ##1 sck_o [*4];
    endsequence

    a_conv_lines_high: assert property (converting_o && !ext_mode_o |-> sck_o && sdo_o)
        else $error("clock or data low while converting");
    a_eoc_falls: assert property ($fell(converting_o) && sdo_oe_o |-> !sdo_o)
        else $error("data not low at conversion end");
    a_low_phase_len: assert property ($fell(sck_o) && sck_oe_o && !ext_mode_o |-> s_low_half)
        else $error("clock low phase too short");
    a_high_phase_len: assert property ($rose(sck_o) && sck_oe_o && !ext_mode_o |-> s_high_half)
        else $error("clock high phase too short");
    a_first_bit_eoc: assert property ($rose(sck_o) && sck_oe_o && rises == 5'h00 |-> !sdo_o)
        else $error("first bit is not a low flag");
    a_frame_restart: assert property ($rose(sck_o) && sck_oe_o && rises == 5'h17
        |-> ##[18:22] (conv_start_o && sdo_o && sck_o))
        else $error("no restart after last rising edge");
    a_frame_edge_count: assert property (conv_start_o && rises != 5'h00 |-> rises == FRAME_LAST)
        else $error("frame edge count wrong");
    a_cs_held_high: assert property (converting_o |-> cs_pullup_o && !cs_sink_o)
        else $error("select not pulled up while converting");
    a_auto_sleep: assert property (cs_sink_o |-> !cs_pullup_o && !sck_oe_o && sck_pullup_o && !converting_o)
        else $error("discharge state wrong");
    a_por_pullup: assert property (!sdo_oe_o |-> sck_pullup_o && !sck_oe_o && !converting_o)
        else $error("clock pin not released during power-on");
endmodule

bind aics_serial_out aics_serial_out_asserts #(.POR_CYCLES(POR_CYCLES)) u_asserts (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .sck_o        (sck_o),
    .sck_oe_o     (sck_oe_o),
    .sck_pullup_o (sck_pullup_o),
    .cs_pullup_o  (cs_pullup_o),
    .cs_sink_o    (cs_sink_o),
    .sdo_o        (sdo_o),
    .sdo_oe_o     (sdo_oe_o),
    .conv_start_o (conv_start_o),
    .ext_mode_o   (ext_mode_o),
    .converting_o (converting_o)
);

// file: verification/aics_ctrl_model.sv
`timescale 1ns/10ps
module aics_ctrl_model (
    input  wire logic        resetn_i,
    input  wire logic        sck_w_i,
    input  wire logic        sdo_w_i,
    input  wire logic        go_i,
    output logic             sck_drv_o,
    output logic      [23:0] frame_o,
    output int               frames_o
);
    int          cnt = 0;
    logic [23:0] sh  = 24'h000000;

    initial begin
        sck_drv_o = 1'b0;
        frame_o = 24'h000000;
        frames_o = 0;
    end
    always @(negedge resetn_i) begin
        cnt = 0;
    end
    // every bit taken on a rising edge, 24 to a frame
    always @(posedge sck_w_i) begin
        if (resetn_i) begin
            sh = {sh[22:0], sdo_w_i};
            cnt = cnt + 1;
            if (cnt == 24) begin
                frame_o = sh;
                frames_o++;
                cnt = 0;
            end
        end
    end
    // external clock, 160 ns period, rests low between frames
    always @(posedge go_i) begin
        repeat (24) begin
            #80 sck_drv_o = 1'b1;
            #80 sck_drv_o = 1'b0;
        end
    end
endmodule

// file: verification/aics_serial_out_tb.sv
`timescale 1ns/10ps
module aics_serial_out_tb;
    import aics_pkg::*;
    localparam int unsigned POR_N = 20;
    localparam int unsigned DIS_N = 64;
    logic                clk_i = 1'b0;
    logic                resetn_i = 1'b0;
    logic                cs_gnd = 1'b1;
    logic                ext_en = 1'b0;
    logic                go = 1'b0;
    logic                flt = 1'b0;
    logic                res_valid_i = 1'b0;
    logic [RESULT_W-1:0] res_data_i = '0;
    logic [7:0]          cap = 8'h00;
    logic                sck_o, sck_oe_o, sck_pullup_o, cs_pullup_o, cs_sink_o, sdo_o, sdo_oe_o;
    logic                conv_start_o, res_ready_o, ext_mode_o, autostart_o, converting_o, m_drv;
    logic [23:0]         frame;
    int                  frames;
    int                  n_mismatch = 0;
    int                  checks = 0;
    wire                 sck_w = sck_oe_o ? sck_o : (ext_en ? m_drv : (sck_pullup_o ? 1'b1 : flt));
    wire                 sdo_w = sdo_oe_o ? sdo_o : flt;
    wire                 cs_i = !cs_gnd && (cap != 8'h00);

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) flt <= ~flt;
    // capacitor on select: charged by the pull-up, drained by the sink
    always @(posedge clk_i) begin
        if (cs_pullup_o) begin
            cap <= DIS_N[7:0];
        end else if (cs_sink_o && cap != 8'h00) begin
            cap <= cap - 8'h01;
        end
    end

    aics_serial_out #(.POR_CYCLES(POR_N)) DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .supply_ok_i(1'b1), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_o(sck_oe_o), .sck_pullup_o(sck_pullup_o), .cs_i(cs_i), .cs_pullup_o(cs_pullup_o),
        .cs_sink_o(cs_sink_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .conv_start_o(conv_start_o),
        .res_valid_i(res_valid_i), .res_ready_o(res_ready_o), .res_data_i(res_data_i),
        .sleep_cycles_i(16'h0040), .ext_mode_o(ext_mode_o), .autostart_o(autostart_o),
        .converting_o(converting_o));
    aics_ctrl_model u_ctrl (.resetn_i(resetn_i), .sck_w_i(sck_w), .sdo_w_i(sdo_w), .go_i(go),
        .sck_drv_o(m_drv), .frame_o(frame), .frames_o(frames));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // holds valid up on return so calls may follow back to back
    task automatic push(input logic [RESULT_W-1:0] w);
        logic rdy;
        rdy = 1'b0;
        res_valid_i = 1'b1;
        res_data_i = w;
        for (int k = 0; k < 3000 && !rdy; k++) begin
            #2;
            rdy = res_ready_o;
            tick(1);
        end
        check(24'(rdy), 24'h1);
    endtask
    task automatic wait_start(input int n);
        tick(1);
        for (int k = 0; k < n && conv_start_o !== 1'b1; k++)
            tick(1);
        check(24'(conv_start_o), 24'h1);
    endtask
    task automatic wait_conv();
        for (int k = 0; k < 3000 && converting_o !== 1'b1; k++)
            tick(1);
        check(24'(converting_o), 24'h1);
    endtask

    task automatic t_cont();
        logic [RESULT_W-1:0] w[2];
        w = '{23'h5a5a5a, 23'h000001};
        wait_conv();
        check(24'({ext_mode_o, sdo_oe_o}), 24'h1);
        push(w[0]);
        push(w[1]);
        res_valid_i = 1'b0;
        for (int i = 0; i < 2; i++) begin
            wait_start(3000);
            check(frame, {EOC_READY, w[i]});
            check(24'({sdo_o, sck_o}), 24'h3);
        end
    endtask
    task automatic t_fifo();
        logic [RESULT_W-1:0] q[$];
        logic rdy;
        rdy = 1'b1;
        res_valid_i = 1'b1;
        for (int k = 0; k < 16 && rdy; k++) begin
            res_data_i = 23'h100000 + 23'(k);
            q.push_back(res_data_i);
            #2;
            rdy = res_ready_o;
            tick(1);
        end
        res_valid_i = 1'b0;
        if (!rdy)
            void'(q.pop_back());
        check(24'({rdy, q.size() >= 9}), 24'h1);
        while (q.size() > 0) begin
            wait_start(3000);
            check(frame, {EOC_READY, q.pop_front()});
        end
    endtask
    task automatic t_auto();
        int k;
        cs_gnd = 1'b0;
        tick(8);
        push(23'h3c3c3c);
        res_valid_i = 1'b0;
        for (k = 0; k < 3000 && cs_sink_o !== 1'b1; k++)
            tick(1);
        check(24'({autostart_o, sck_oe_o, cs_pullup_o, cs_sink_o}), 24'h9);
        for (k = 0; k < 3000 && sck_oe_o !== 1'b1; k++)
            tick(1);
        check(24'({sck_oe_o, k > DIS_N, k < DIS_N + 16}), 24'h7);
        wait_start(3000);
        check(frame, {EOC_READY, 23'h3c3c3c});
        check(24'({cs_pullup_o, ext_mode_o}), 24'h2);
    endtask
    task automatic t_ext();
        resetn_i = 1'b0;
        ext_en = 1'b1;
        cs_gnd = 1'b1;
        tick(2);
        resetn_i = 1'b1;
        wait_conv();
        check(24'(ext_mode_o), 24'h1);
        push(23'h2aaaab);
        res_valid_i = 1'b0;
        tick(20);
        check(24'(sdo_o), 24'h0);
        go = 1'b1;
        wait_start(3000);
        go = 1'b0;
        check(frame, {EOC_READY, 23'h2aaaab});
        check(24'(sdo_o), 24'h1);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        tick(2);
        resetn_i = 1'b1;
        t_cont();
        t_fifo();
        t_auto();
        t_ext();
        results();
    end
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
endmodule
